// [hdl/hpr_ratio_ctrl.v]
`timescale 1ns/10ps
`default_nettype none
`include "hpr_regs.vh"

module hpr_ratio_ctrl
(
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        refInput,
    input  wire        gapToleranceEnable,
    input  wire        outputWhileUnlocked,
    input  wire [2:0]  minLoopBandwidthSel,
    input  wire [1:0]  staticRatioSelect,
    input  wire [1:0]  dynamicRatioSelect,
    input  wire        ratioFormatSelect,
    input  wire        fractionSourceSelect,
    input  wire [2:0]  modifierSelect,
    input  wire        slotWrite,
    input  wire [1:0]  slotIndex,
    input  wire [31:0] slotData,
    input  wire [1:0]  timingRefDivShift,
    output reg         pllLocked,
    output reg         outputEnable,
    output reg         refPresent,
    output reg         autoSourceActive,
    output reg         hybridMode,
    output reg         ratioFormat,
    output reg  [3:0]  loopBandwidth,
    output reg  [31:0] userRatio,
    output reg  [31:0] effectiveRatio,
    output reg  [31:0] timingRatio
);

// ----------------------------------------------------------------
// reference input synchroniser
// ----------------------------------------------------------------
// three stages; a level change counts once stages two and three agree
reg       refSync1;
reg       refSync2;
reg       refSync3;
reg       refLevel;
// rising edges only; a pulse shorter than two core clocks never counts
wire      refEdge = (refSync2 == refSync3) && (refSync3 != refLevel) && refSync3;

// first stage feeds only the second
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        refSync1 <= 1'b0;
        refSync2 <= 1'b0;
        refSync3 <= 1'b0;
        refLevel <= 1'b0;
    end
    else
    begin
        refSync1 <= refInput;
        refSync2 <= refSync1;
        refSync3 <= refSync2;
        if (refSync2 == refSync3)
            refLevel <= refSync3;
    end
end

// ----------------------------------------------------------------
// loss timer and period tracking
// ----------------------------------------------------------------
reg  [`HPR_LOSS_W-1:0] lossCount;
reg  [`HPR_LOSS_W-1:0] lastPeriod;
reg                    periodValid;
// the gap timer only has to reach the tolerance time, so it stops there
reg  [31:0]            gapCount;
reg  [7:0]             acqCount;
// the timeout spans about a fifth of a second, so the counter saturates rather than wrapping;
// a wrap would fake a fresh period after a long loss
wire                   lossTimeout = (lossCount == `HPR_LOSS_MAX);
wire                   gapOverTol  = (gapCount >= `HPR_GAP_CYC);
// a period change means the source went away dirty or changed frequency
wire [`HPR_LOSS_W-1:0] perDiff = (lossCount > lastPeriod) ? (lossCount - lastPeriod)
                                                          : (lastPeriod - lossCount);
wire                   periodJump = refEdge && periodValid && (perDiff > `HPR_PER_TOL);
// edge overdue against the known period: the reference has stopped;
// holdover or reacquire is the lock machine's call, so the gap
// tolerance bit is not looked at here
wire                   overdue = periodValid && !lossTimeout
                                 && (lossCount > lastPeriod + `HPR_PER_TOL);

// counter restarts on every edge, saturates at the timeout
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        lossCount   <= `HPR_ZERO23;
        lastPeriod  <= `HPR_ZERO23;
        periodValid <= 1'b0;
        gapCount    <= `HPR_ZERO32;
    end
    else if (refEdge)
    begin
        lossCount   <= `HPR_ZERO23;
        lastPeriod  <= lossCount;
        // an edge that ends a gap measures the gap, not a period; the next
        // edge must not be judged against it or every restart looks like a jump
        periodValid <= !lossTimeout && refPresent && !overdue;
        gapCount    <= `HPR_ZERO32;
    end
    else
    begin
        if (!lossTimeout)
            lossCount <= lossCount + `HPR_ONE23;
        if (!gapOverTol)
            gapCount <= gapCount + 32'h00000001;
    end
end

// ----------------------------------------------------------------
// lock state machine
// ----------------------------------------------------------------
localparam ST_IDLE = 2'b00;   // no reference, unlocked
localparam ST_ACQ  = 2'b01;   // acquiring lock
localparam ST_LOCK = 2'b10;   // locked
localparam ST_HOLD = 2'b11;   // reference missing, output continues

reg  [1:0] state;
reg  [1:0] next_state;
reg        skipRun;           // output continuity granted by a tolerated gap
reg        next_skipRun;

// loss timeout only in clean absence; a period jump unlocks at once
always @*
begin
    next_state   = state;
    next_skipRun = skipRun;
    case (state)
        ST_IDLE:
        begin
            next_skipRun = 1'b0;
            if (refEdge)
                next_state = ST_ACQ;
        end
        ST_ACQ:
        begin
            if (lossTimeout)
            begin
                next_state   = ST_IDLE;
                next_skipRun = 1'b0;
            end
            else if (acqCount == `HPR_ACQ_EDGES)
            begin
                next_state   = ST_LOCK;
                next_skipRun = 1'b0;
            end
        end
        ST_LOCK:
        begin
            if (periodJump)
            begin
                // a frequency change ends any continuity granted by a gap
                next_state   = ST_ACQ;
                next_skipRun = 1'b0;
            end
            else if (!refEdge && overdue)
            begin
                // clean stop: output runs on until timeout or return,
                // whatever the gap tolerance setting
                next_state = ST_HOLD;
            end
        end
        ST_HOLD:
        begin
            if (lossTimeout)
                next_state = ST_IDLE;
            else if (refEdge)
            begin
                // short gap with tolerance: keep output and skip reacquire
                next_skipRun = gapToleranceEnable && !gapOverTol;
                // tolerance on keeps lock for gaps up to the tolerance time
                next_state   = next_skipRun ? ST_LOCK : ST_ACQ;
            end
        end
        default:
        begin
            next_state   = ST_IDLE;
            next_skipRun = 1'b0;
        end
    endcase
end

always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        state    <= ST_IDLE;
        skipRun  <= 1'b0;
        acqCount <= `HPR_ZERO8;
    end
    else
    begin
        state   <= next_state;
        skipRun <= next_skipRun;
        // the edge count only runs inside acquire, so every fresh acquire
        // waits the full count
        if (next_state != ST_ACQ)
            acqCount <= `HPR_ZERO8;
        else if (refEdge && acqCount != `HPR_ACQ_EDGES)
            acqCount <= acqCount + 8'h01;
    end
end

// ----------------------------------------------------------------
// ratio slots
// ----------------------------------------------------------------
// slots only change on a write; the modifier never touches them
reg [31:0] ratioSlot [0:3];
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : gSlot
        always @(posedge core_clk)
        begin
            if (sys_rst)
                ratioSlot[gi] <= `HPR_ZERO32;
            else if (slotWrite && slotIndex == gi)
                ratioSlot[gi] <= slotData;
        end
    end
endgenerate

// ----------------------------------------------------------------
// source, format and ratio arithmetic
// ----------------------------------------------------------------
// equal selects leave the source to software; differing ones hand it to the reference
wire        autoMode  = (dynamicRatioSelect != staticRatioSelect);
wire        refUp     = (state != ST_IDLE);
wire        useHybrid = autoMode ? refUp : fractionSourceSelect;
// 20.12 only with format bit clear and dynamic source chosen
wire        fmtNow    = (!ratioFormatSelect && useHybrid) ? `HPR_FMT_HIMULT
                                                          : `HPR_FMT_HIRES;
wire [1:0]  slotSel   = useHybrid ? dynamicRatioSelect : staticRatioSelect;
wire [31:0] udRatio   = ratioSlot[slotSel];
// modifier table; only the selected copy is scaled, never the slot.
// up-shifts drop top bits and down-shifts drop fraction bits, so codes
// that overflow or truncate the chosen format are software's to avoid
reg  [31:0] modRatio;
always @*
begin
    modRatio = udRatio;
    case (modifierSelect)
        `HPR_MOD_X1:  modRatio = udRatio;
        `HPR_MOD_X2:  modRatio = udRatio << 3'h1;
        `HPR_MOD_X4:  modRatio = udRatio << 3'h2;
        `HPR_MOD_X8:  modRatio = udRatio << 3'h3;
        `HPR_MOD_D2:  modRatio = udRatio >> 3'h1;
        `HPR_MOD_D4:  modRatio = udRatio >> 3'h2;
        `HPR_MOD_D8:  modRatio = udRatio >> 3'h3;
        `HPR_MOD_D16: modRatio = udRatio >> 3'h4;
        default:      modRatio = udRatio;
    endcase
end
// internal dividers compensated here; normalise to 12.20 then scale
wire [31:0] hiRes     = (fmtNow == `HPR_FMT_HIMULT) ? (modRatio << `HPR_FMT_SHIFT) : modRatio;
wire [31:0] corrected = hiRes << timingRefDivShift;

// ----------------------------------------------------------------
// registered outputs
// ----------------------------------------------------------------
// holdover counts as locked: the loop is not reacquiring then, so the
// bandwidth stays at the chosen minimum rather than opening up
wire        lockedNext = (next_state == ST_LOCK) || (next_state == ST_HOLD);

// lock status, output gating and loop bandwidth
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        pllLocked     <= 1'b0;
        outputEnable  <= 1'b0;
        refPresent    <= 1'b0;
        loopBandwidth <= `HPR_BW_WIDE;
    end
    else
    begin
        pllLocked     <= lockedNext;
        // hold keeps output running until timeout; skip returns straight to lock
        outputEnable  <= lockedNext || next_skipRun || outputWhileUnlocked;
        refPresent    <= refUp;
        // wide loop while acquiring, then the chosen minimum
        loopBandwidth <= lockedNext ? {1'b0, minLoopBandwidthSel}
                                    : `HPR_BW_WIDE;
    end
end

// source, format and ratio path; one cycle behind the selects
always @(posedge core_clk)
begin
    if (sys_rst)
    begin
        autoSourceActive <= 1'b0;
        hybridMode       <= 1'b0;
        ratioFormat      <= `HPR_FMT_HIMULT;
        userRatio        <= `HPR_ZERO32;
        effectiveRatio   <= `HPR_ZERO32;
        timingRatio      <= `HPR_ZERO32;
    end
    else
    begin
        autoSourceActive <= autoMode;
        hybridMode       <= useHybrid;
        ratioFormat      <= fmtNow;
        userRatio        <= udRatio;
        effectiveRatio   <= modRatio;
        timingRatio      <= corrected;
    end
end

endmodule
`default_nettype wire

// [hdl/hpr_regs.vh]
`ifndef HPR_REGS_VH
`define HPR_REGS_VH
// loss timeout: 2^23 internal timing clock cycles
`define HPR_LOSS_W        23
`define HPR_LOSS_MAX      23'h7FFFFF
// gap tolerance time 20 ms at 40 MHz core clock (exact cycle count)
`define HPR_GAP_MS        20
`define HPR_CLK_KHZ       40000
`define HPR_GAP_CYC       (`HPR_GAP_MS * `HPR_CLK_KHZ)
// lock acquisition time in reference edges
`define HPR_ACQ_EDGES     8'h10
// period match tolerance in internal timing clock cycles
`define HPR_PER_TOL       23'h000004
// bandwidth code used while acquiring
`define HPR_BW_WIDE       4'h8
// formats
`define HPR_FMT_HIRES     1'b1
`define HPR_FMT_HIMULT    1'b0
// shift amounts between formats
`define HPR_FMT_SHIFT     8
// modifier codes: unity and three up-shifts, then four down-shifts
`define HPR_MOD_X1        3'h0
`define HPR_MOD_X2        3'h1
`define HPR_MOD_X4        3'h2
`define HPR_MOD_X8        3'h3
`define HPR_MOD_D2        3'h4
`define HPR_MOD_D4        3'h5
`define HPR_MOD_D8        3'h6
`define HPR_MOD_D16       3'h7
// fixed reset values and the loss counter increment
`define HPR_ZERO32        32'h00000000
`define HPR_ZERO23        23'h000000
`define HPR_ZERO8         8'h00
`define HPR_ZERO3         3'h0
`define HPR_ONE23         23'h000001
`endif

// [sim/hpr_ratio_ctrl_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module hpr_ratio_ctrl_properties (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        outputWhileUnlocked,
    input wire logic [2:0]  minLoopBandwidthSel,
    input wire logic [1:0]  staticRatioSelect,
    input wire logic [1:0]  dynamicRatioSelect,
    input wire logic        fractionSourceSelect,
    input wire logic [2:0]  modifierSelect,
    input wire logic [1:0]  timingRefDivShift,
    input wire logic        pllLocked,
    input wire logic        outputEnable,
    input wire logic        autoSourceActive,
    input wire logic        ratioFormat,
    input wire logic [3:0]  loopBandwidth,
    input wire logic [31:0] userRatio,
    input wire logic [31:0] effectiveRatio,
    input wire logic [31:0] timingRatio
);
    default clocking cb @(posedge core_clk); endclocking
    // reset is released by the edge that samples it; one extra cycle keeps
    // attempts that start on that edge from judging reset values
    logic rstDly;
    always @(posedge core_clk)
        rstDly <= sys_rst;
    default disable iff (sys_rst || rstDly);
    // unlocked and quiet for two cycles, so the registered output has caught up
    sequence s_unl_quiet;
        (!pllLocked && !outputWhileUnlocked) [*2];
    endsequence
    a_out_low_unl: assert property (s_unl_quiet |-> !outputEnable)
        else $error("output runs while unlocked");
    a_lock_out_on: assert property (pllLocked |-> outputEnable)
        else $error("output off while locked");
    a_bw_wide_acq: assert property (!pllLocked && !$past(pllLocked) |-> loopBandwidth == 4'h8)
        else $error("bandwidth not wide while acquiring");
    a_bw_min_lock: assert property (pllLocked && $past(pllLocked) && $stable(minLoopBandwidthSel)
        |-> loopBandwidth == {1'b0, minLoopBandwidthSel})
        else $error("bandwidth not minimum when locked");
    a_auto_sel: assert property (1'b1 |=> autoSourceActive ==
        ($past(staticRatioSelect) != $past(dynamicRatioSelect)))
        else $error("automatic source flag wrong");
    a_fmt_static: assert property (!fractionSourceSelect && staticRatioSelect == dynamicRatioSelect
        |=> ratioFormat)
        else $error("static source not high resolution");
    // modifier: low two bits pick the shift, top bit picks the direction
    a_mod_scale: assert property ($stable(userRatio) && $stable(modifierSelect) |-> effectiveRatio ==
        (modifierSelect[2] ? userRatio >> (modifierSelect[1:0] + 1) : userRatio << modifierSelect[1:0]))
        else $error("effective ratio scaling wrong");
    a_timing_conv: assert property ($stable(effectiveRatio) && $stable(ratioFormat)
        && $stable(timingRefDivShift)
        |-> timingRatio == ((ratioFormat ? effectiveRatio : effectiveRatio << 8) << timingRefDivShift))
        else $error("timing ratio conversion wrong");
endmodule
bind hpr_ratio_ctrl hpr_ratio_ctrl_properties hpr_ratio_ctrl_properties_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .outputWhileUnlocked(outputWhileUnlocked), .minLoopBandwidthSel(minLoopBandwidthSel),
    .staticRatioSelect(staticRatioSelect), .dynamicRatioSelect(dynamicRatioSelect),
    .fractionSourceSelect(fractionSourceSelect), .modifierSelect(modifierSelect),
    .timingRefDivShift(timingRefDivShift), .pllLocked(pllLocked), .outputEnable(outputEnable),
    .autoSourceActive(autoSourceActive), .ratioFormat(ratioFormat), .loopBandwidth(loopBandwidth),
    .userRatio(userRatio), .effectiveRatio(effectiveRatio), .timingRatio(timingRatio));
`default_nettype wire

// [sim/hpr_ref_source.sv]
`timescale 1ns/10ps
`default_nettype none
module hpr_ref_source (
    input  wire logic        core_clk,
    input  wire logic        runRef,
    input  wire logic [15:0] halfPer,
    output var  logic        refOut
);
    logic [15:0] cnt;
    initial refOut = 1'b0;
    initial cnt = 16'h0000;
    // stands low while stopped so no stray edge reaches the pin
    always @(posedge core_clk)
    begin
        if (!runRef)
        begin
            refOut <= 1'b0;
            cnt <= 16'h0000;
        end
        else if (cnt >= halfPer - 16'h0001)
        begin
            refOut <= ~refOut;
            cnt <= 16'h0000;
        end
        else
            cnt <= cnt + 16'h0001;
    end
endmodule
`default_nettype wire

// [sim/hpr_ratio_ctrl_test.sv]
`timescale 1ns/10ps
`default_nettype none
module hpr_ratio_ctrl_test;
    logic        core_clk, sys_rst, runRef, gapTol, owu, fracSrc, fmtSel, slotWr;
    logic        refIn, locked, outEn, autoAct, hyb, fmt;
    logic [1:0]  statSel, dynSel, slotIdx, divSh;
    logic [2:0]  bwSel, modSel;
    logic [3:0]  loopBw;
    logic [15:0] halfPer;
    logic [31:0] slotDat, usr, eff, tim;
    logic [31:0] slots [4];
    int          error_cnt, num_checks;

    hpr_ratio_ctrl hpr_ratio_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst), .refInput(refIn),
        .gapToleranceEnable(gapTol), .outputWhileUnlocked(owu), .minLoopBandwidthSel(bwSel),
        .staticRatioSelect(statSel), .dynamicRatioSelect(dynSel), .ratioFormatSelect(fmtSel),
        .fractionSourceSelect(fracSrc), .modifierSelect(modSel), .slotWrite(slotWr), .slotIndex(slotIdx),
        .slotData(slotDat), .timingRefDivShift(divSh), .pllLocked(locked), .outputEnable(outEn),
        .refPresent(), .autoSourceActive(autoAct), .hybridMode(hyb), .ratioFormat(fmt),
        .loopBandwidth(loopBw), .userRatio(usr), .effectiveRatio(eff), .timingRatio(tim));
    hpr_ref_source hpr_ref_source_inst (.core_clk(core_clk), .runRef(runRef), .halfPer(halfPer), .refOut(refIn));

    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
        end
    endtask
    task chk_flag(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // bounded wait; the lock takes sixteen reference edges
    task wait_lock(input logic v);
        int n;
        n = 0;
        while (locked !== v && n < 20000)
        begin
            tick(1);
            n++;
        end
        chk_flag(locked, v);
    endtask
    function logic [31:0] scl(input logic [31:0] r, input logic [2:0] c);
        return c[2] ? r >> (c[1:0] + 1) : r << c[1:0];
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // back-to-back slot writes, then every slot under every modifier code
    task t_slots;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            slotWr <= 1'b1;
            slotIdx <= i[1:0];
            slotDat <= slots[i];
        end
        @(posedge core_clk);
        slotWr <= 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            @(posedge core_clk);
            statSel <= i[4:3];
            dynSel <= i[4:3];
            modSel <= i[2:0];
            tick(3);
            chk_val(usr, slots[i[4:3]]);
            chk_val(eff, scl(slots[i[4:3]], i[2:0]));
            chk_val(tim, scl(slots[i[4:3]], i[2:0]) << divSh);
            chk_flag(fmt, 1'b1);
        end
        // automatic mode with no reference yet: format bit and manual source ignored
        @(posedge core_clk);
        statSel <= 2'h0;
        dynSel <= 2'h1;
        fracSrc <= 1'b1;
        tick(3);
        chk_flag(fmt, 1'b1);
        chk_flag(hyb, 1'b0);
        chk_val(usr, slots[0]);
    endtask
    task t_lock;
        @(posedge core_clk);
        runRef <= 1'b1;
        tick(700);
        chk_flag(outEn, 1'b0);
        chk_val({28'h0, loopBw}, 32'h00000008);
        wait_lock(1'b1);
        for (int b = 0; b < 8; b++)
        begin
            @(posedge core_clk);
            bwSel <= b[2:0];
            tick(3);
            chk_val({28'h0, loopBw}, {29'h0, b[2:0]});
        end
    endtask
    task t_hybrid;
        @(posedge core_clk);
        fracSrc <= 1'b1;
        modSel <= 3'h0;
        statSel <= 2'h1;
        dynSel <= 2'h1;
        tick(4);
        chk_flag(hyb, 1'b1);
        chk_flag(fmt, 1'b0);
        chk_val(tim, (slots[1] << 8) << divSh);
        fmtSel <= 1'b1;
        tick(4);
        chk_flag(fmt, 1'b1);
        fracSrc <= 1'b0;
        dynSel <= 2'h2;
        statSel <= 2'h0;
        tick(4);
        chk_flag(autoAct, 1'b1);
        chk_flag(hyb, 1'b1);
        chk_val(usr, slots[2]);
        dynSel <= 2'h0;
    endtask
    // short gap with tolerance on: output must never stop
    task t_gap;
        int drops;
        drops = 0;
        @(posedge core_clk);
        runRef <= 1'b0;
        for (int n = 0; n < 12000; n++)
        begin
            tick(1);
            if (outEn !== 1'b1)
                drops++;
            if (n == 1500)
                runRef <= 1'b1;
        end
        chk_val(drops, 32'h00000000);
        chk_flag(locked, 1'b1);
    endtask
    // period jump drops lock at once; the unlocked output follows the setting
    task t_jump;
        @(posedge core_clk);
        gapTol <= 1'b0;
        halfPer <= 16'h0096;
        wait_lock(1'b0);
        tick(2);
        chk_flag(outEn, 1'b0);
        wait_lock(1'b1);
        owu <= 1'b1;
        halfPer <= 16'h012C;
        wait_lock(1'b0);
        tick(2);
        chk_flag(outEn, 1'b1);
        wait_lock(1'b1);
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // limit well above the roughly forty thousand cycles the scenarios need
    initial
    begin
        tick(90000);
        error_cnt++;
        finish_test;
    end
    initial
    begin
        {sys_rst, gapTol} = 2'h3;
        {runRef, owu, fracSrc, fmtSel, slotWr} = 5'h00;
        {statSel, dynSel, slotIdx, bwSel, modSel} = 12'h000;
        {divSh, halfPer, slotDat} = {2'h1, 16'h012C, 32'h00000000};
        slots = '{32'h00123450, 32'h00ABC000, 32'h01F00F10, 32'h00345670};
        tick(4);
        sys_rst <= 1'b0;
        tick(1);
        t_slots;
        t_lock;
        t_hybrid;
        t_gap;
        t_jump;
        finish_test;
    end
endmodule
`default_nettype wire
